//--- dpd_regs.svh
// Register offsets, field positions and reset values of the digital I/O block
`ifndef DPD_REGS_SVH
`define DPD_REGS_SVH

`define DPD_ADDR_W 8
`define DPD_DIR_OFS 8'h00
`define DPD_OUT_OFS 8'h04
`define DPD_IN_OFS 8'h08
`define DPD_SAMP_OFS 8'h0C
`define DPD_CNT_BASE 8'h10
`define DPD_CNT_STRIDE 8'h08
`define DPD_CNT_CTL_SUB 1'b0
`define DPD_CNT_VAL_SUB 1'b1

`define DPD_DIR_RESET 4'hC
`define DPD_OUT_RESET 32'h0000_0000
`define DPD_CTL_RESET 20'h0_0000

`define DPD_CTL_SEL_A_LSB 0
`define DPD_CTL_EN_A_BIT 5
`define DPD_CTL_SEL_B_LSB 6
`define DPD_CTL_EN_B_BIT 11
`define DPD_CTL_SEL_R_LSB 12
`define DPD_CTL_EN_R_BIT 17
`define DPD_CTL_MODE_LSB 18

`endif

//--- dpd_pkg.sv
// Types shared by the digital I/O block
package dpd_pkg;
  typedef enum logic [1:0] {DPD_PLAIN, DPD_UPDOWN, DPD_ENCODER} dpd_mode_t;
  typedef logic [4:0] dpd_sel_t;
endpackage

//--- dpd_top.sv
// Dual 16-line digital port with three routable 32-bit counters
//
// Summary of operation
// RULE1: Two ports of sixteen lines, each line input or output by software.
// RULE2: Direction is set per group of eight adjacent lines.
// RULE3: After reset the first port is input, the second port output.
// RULE4: Input lines are latched on the analog sampling strobe, time-aligned.
// RULE5: Outside circuits must not drive lines the block drives.
// RULE6: Three independent 32-bit counters for pulses or incremental encoders.
// RULE7: Pulse, phase and reset inputs each select any line of either port.
// RULE8: A counter stays idle until its lines are assigned by software.
// RULE9: Software sets every line used by a counter to input first.
// RULE10: Plain mode counts each rising pulse edge, up to 16 MHz.
// RULE11: At range maximum the next count wraps to range minimum.
// RULE12: An assigned external reset line clears the counter at any time.
// RULE13: Quadrature mode uses the second phase to count up or down.
// RULE14: Plain range unsigned; up/down and encoder signed; encoder to 4 MHz.
// RULE15: Counter inputs are synchronised and edge-detected, not debounced.
`include "dpd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dpd_top
  import dpd_pkg::*;
#(
  parameter int PORT_W = 16,
  parameter int GROUP_W = 8,
  parameter int NUM_CNT = 3,
  parameter int CNT_W = 32
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [`DPD_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sample_strobe_i,
  input wire logic [PORT_W-1:0] port_a_in_i,
  output logic [PORT_W-1:0] port_a_out_o,
  output logic [PORT_W-1:0] port_a_oe_o,
  input wire logic [PORT_W-1:0] port_b_in_i,
  output logic [PORT_W-1:0] port_b_out_o,
  output logic [PORT_W-1:0] port_b_oe_o
);

  localparam int NUM_GRP = 2 * PORT_W / GROUP_W;
  localparam int LINES = 2 * PORT_W;

  // Elaboration check of parameters the logic can serve
  if (PORT_W != 16 || GROUP_W != 8 || CNT_W != 32 || NUM_CNT < 1 || NUM_CNT > 3) begin : g_chk
    $error("dpd_top: unsupported parameter set");
  end

  // Bus state
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [NUM_GRP-1:0] dir;
  logic [NUM_GRP-1:0] next_dir;
  logic [LINES-1:0] out_val;
  logic [LINES-1:0] next_out_val;
  logic [LINES-1:0] samp;
  logic [LINES-1:0] next_samp;
  logic [19:0] ctl [NUM_CNT];
  logic [19:0] next_ctl [NUM_CNT];
  logic [CNT_W-1:0] cnt [NUM_CNT];
  logic [CNT_W-1:0] next_cnt [NUM_CNT];

  // Input synchroniser and edge history
  logic [LINES-1:0] sync1;
  logic [LINES-1:0] sync2;
  logic [LINES-1:0] prev;
  logic [LINES-1:0] pins;

  function automatic logic pick(input logic [LINES-1:0] v, input dpd_sel_t s);
    pick = v[s];
  endfunction

  // Rising edge of a synchronised line against its value one clock earlier
  function automatic logic rise(input logic now_v, input logic old_v);
    rise = now_v & ~old_v;
  endfunction

  // Any change of a synchronised line between two clocks
  function automatic logic moved(input logic now_v, input logic old_v);
    moved = now_v ^ old_v;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge_be = r;
  endfunction

  assign pins = {port_b_in_i, port_a_in_i};

  // Pins are driven only for groups set to output; see RULE5
  always_comb begin
    port_a_oe_o = '0;
    port_b_oe_o = '0;
    for (int g = 0; g < NUM_GRP / 2; g++) begin
      port_a_oe_o[g*GROUP_W +: GROUP_W] = {GROUP_W{dir[g]}}; // see RULE2
      port_b_oe_o[g*GROUP_W +: GROUP_W] = {GROUP_W{dir[g + NUM_GRP / 2]}}; // see RULE2
    end
  end
  assign port_a_out_o = out_val[PORT_W-1:0];
  assign port_b_out_o = out_val[LINES-1:PORT_W];

  // Slave answers one cycle after the request with waitrequest low
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign avs_readdata_o = rdata;

  logic [`DPD_ADDR_W-1:0] word_addr;
  logic in_cnt;
  logic [`DPD_ADDR_W-1:0] cnt_rel;
  int unsigned cnt_idx;
  logic cnt_sub;
  logic do_wr;
  logic [31:0] line_in;

  always_comb begin
    word_addr = {avs_address_i[`DPD_ADDR_W-1:2], 2'b00};
    cnt_rel = word_addr - `DPD_CNT_BASE;
    in_cnt = (word_addr >= `DPD_CNT_BASE) &&
             (cnt_rel < 8'(NUM_CNT * `DPD_CNT_STRIDE));
    cnt_idx = 32'(cnt_rel[`DPD_ADDR_W-1:3]);
    cnt_sub = cnt_rel[2];
    do_wr = avs_write_i & ack;
    line_in = 32'(sync2);

    next_ack = (avs_read_i | avs_write_i) & ~ack;
    next_rdata = rdata;
    next_dir = dir;
    next_out_val = out_val;
    next_samp = samp;

    // Digital inputs latched at the analog sampling instant; see RULE4
    if (sample_strobe_i) begin
      next_samp = sync2;
    end

    if (avs_read_i & ~ack) begin
      next_rdata = 32'h0000_0000;
      if (word_addr == `DPD_DIR_OFS) begin
        next_rdata = 32'(dir);
      end else if (word_addr == `DPD_OUT_OFS) begin
        next_rdata = 32'(out_val);
      end else if (word_addr == `DPD_IN_OFS) begin
        next_rdata = line_in;
      end else if (word_addr == `DPD_SAMP_OFS) begin
        next_rdata = 32'(samp);
      end else if (in_cnt) begin
        next_rdata = (cnt_sub == `DPD_CNT_VAL_SUB) ? 32'(cnt[cnt_idx]) : 32'(ctl[cnt_idx]);
      end
    end

    if (do_wr && word_addr == `DPD_DIR_OFS && avs_byteenable_i[0]) begin
      next_dir = avs_writedata_i[NUM_GRP-1:0]; // see RULE1
    end
    if (do_wr && word_addr == `DPD_OUT_OFS) begin
      next_out_val = merge_be(out_val, avs_writedata_i, avs_byteenable_i);
    end
  end

  // Counter engine
  logic a_now;
  logic a_old;
  logic b_now;
  logic b_old;
  logic r_now;
  logic [19:0] c;
  dpd_mode_t mode;
  logic [CNT_W-1:0] step;

  always_comb begin
    a_now = 1'b0;
    a_old = 1'b0;
    b_now = 1'b0;
    b_old = 1'b0;
    r_now = 1'b0;
    c = 20'h0_0000;
    mode = DPD_PLAIN;
    step = '0;
    for (int n = 0; n < NUM_CNT; n++) begin
      next_ctl[n] = ctl[n];
      next_cnt[n] = cnt[n];
      c = ctl[n];
      mode = dpd_mode_t'(c[`DPD_CTL_MODE_LSB +: 2]);
      // Any line of either port may feed each input; see RULE7
      a_now = pick(sync2, c[`DPD_CTL_SEL_A_LSB +: 5]);
      a_old = pick(prev, c[`DPD_CTL_SEL_A_LSB +: 5]);
      b_now = pick(sync2, c[`DPD_CTL_SEL_B_LSB +: 5]);
      b_old = pick(prev, c[`DPD_CTL_SEL_B_LSB +: 5]);
      r_now = pick(sync2, c[`DPD_CTL_SEL_R_LSB +: 5]);
      step = '0;
      case (mode)
        DPD_PLAIN: begin
          // Rising edge of the pulse line counts up, unsigned; see RULE10
          if (c[`DPD_CTL_EN_A_BIT] && rise(a_now, a_old)) begin // see RULE15
            step = CNT_W'(1);
          end
        end
        DPD_UPDOWN: begin
          // Second line level gives direction, signed range; see RULE14
          if (c[`DPD_CTL_EN_A_BIT] && c[`DPD_CTL_EN_B_BIT] && rise(a_now, a_old)) begin
            step = b_now ? '1 : CNT_W'(1); // see RULE13
          end
        end
        DPD_ENCODER: begin
          // Four counts per encoder cycle, direction from phase order; see RULE13
          if (c[`DPD_CTL_EN_A_BIT] && c[`DPD_CTL_EN_B_BIT] &&
              (moved(a_now, a_old) ^ moved(b_now, b_old))) begin
            step = (a_now ^ b_old) ? CNT_W'(1) : '1;
          end
        end
        default: begin
          step = '0;
        end
      endcase
      // No line assigned leaves the counter idle; see RULE8
      if (!c[`DPD_CTL_EN_A_BIT]) begin
        step = '0;
      end
      // Two's complement addition wraps max to min in every mode; see RULE11
      next_cnt[n] = cnt[n] + step; // see RULE6
      if (do_wr && in_cnt && cnt_idx == 32'(n)) begin
        if (cnt_sub == `DPD_CNT_CTL_SUB) begin
          next_ctl[n] = 20'(merge_be(32'(ctl[n]), avs_writedata_i, avs_byteenable_i));
        end else begin
          next_cnt[n] = merge_be(cnt[n], avs_writedata_i, avs_byteenable_i);
        end
      end
      // Assigned reset line clears at any time, over counting; see RULE12
      if (c[`DPD_CTL_EN_R_BIT] && r_now) begin
        next_cnt[n] = '0;
      end
    end
  end

  // Bus handshake and read data
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Port direction, output values and sampled lines
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dir <= `DPD_DIR_RESET; // see RULE3
      out_val <= `DPD_OUT_RESET;
      samp <= '0;
    end else begin
      dir <= next_dir;
      out_val <= next_out_val;
      samp <= next_samp;
    end
  end

  // Two-stage synchroniser and edge history of all lines
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= pins; // see RULE15
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Counter control words and values
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int n = 0; n < NUM_CNT; n++) begin
        ctl[n] <= `DPD_CTL_RESET;
        cnt[n] <= '0;
      end
    end else begin
      for (int n = 0; n < NUM_CNT; n++) begin
        ctl[n] <= next_ctl[n];
        cnt[n] <= next_cnt[n];
      end
    end
  end

endmodule

`default_nettype wire

//--- dpd_top_props.sv
// Checker of bus timing and port direction of the digital I/O block
`timescale 1ns/1ps
`default_nettype none
module dpd_top_props #(
  parameter int PORT_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [PORT_W-1:0] port_a_out_o,
  input wire logic [PORT_W-1:0] port_a_oe_o,
  input wire logic [PORT_W-1:0] port_b_out_o,
  input wire logic [PORT_W-1:0] port_b_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire logic req = avs_read_i | avs_write_i;
  wire logic wr_done = avs_write_i & ~avs_waitrequest_o;
  property p_oe_reset;
    $rose(reset_n_i) |-> port_a_oe_o == '0 && port_b_oe_o == '1;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("oe wrong after reset");
  property p_oe_grp;
    (port_a_oe_o[7:0] == '0 || port_a_oe_o[7:0] == '1) &&
    (port_a_oe_o[15:8] == '0 || port_a_oe_o[15:8] == '1) &&
    (port_b_oe_o[7:0] == '0 || port_b_oe_o[7:0] == '1) &&
    (port_b_oe_o[15:8] == '0 || port_b_oe_o[15:8] == '1);
  endproperty
  a_oe_grp: assert property (p_oe_grp) else $error("oe split in group");
  property p_oe_cause;
    !$stable({port_a_oe_o, port_b_oe_o}) |-> $past(wr_done);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("oe moved without write");
  property p_out_cause;
    !$stable({port_a_out_o, port_b_out_o}) |-> $past(wr_done);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("out moved without write");
  property p_wait_one;
    req && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one");
  property p_wait_idle;
    !req |-> !avs_waitrequest_o;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
  property p_wait_first;
    req && !$past(req) |-> avs_waitrequest_o;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  property p_rd_hold;
    $changed(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata not held");
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_write: cover property (wr_done);
  c_dir: cover property (!$stable(port_a_oe_o));
endmodule
bind dpd_top dpd_top_props #(.PORT_W(PORT_W)) u_props(.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
  .port_a_out_o(port_a_out_o), .port_a_oe_o(port_a_oe_o),
  .port_b_out_o(port_b_out_o), .port_b_oe_o(port_b_oe_o));
`default_nettype wire

//--- dpd_field.sv
// Field side model of the two digital ports
`timescale 1ns/1ps
`default_nettype none
module dpd_field (
  input wire logic [15:0] a_out_i,
  input wire logic [15:0] a_oe_i,
  input wire logic [15:0] b_out_i,
  input wire logic [15:0] b_oe_i,
  input wire logic [31:0] drv_i,
  input wire logic [31:0] drv_en_i,
  output logic [31:0] pin_o
);
  logic [31:0] oe;
  assign oe = {b_oe_i, a_oe_i};
  // Field lets go of driven lines; lines nobody drives fall to the pull-down
  assign pin_o = ({b_out_i, a_out_i} & oe) | (drv_i & drv_en_i & ~oe);
endmodule
`default_nettype wire

//--- dpd_top_tb.sv
// Testbench of the digital I/O block with its field model
`include "dpd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dpd_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic stb = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] drv = 32'h0;
  logic [31:0] den = 32'hFFFFFFFF;
  logic [31:0] rdd, pin, q;
  logic wq;
  logic [15:0] ao, ae, bo, boe;
  int n_mismatch = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  dpd_top u_dut(.clk_sys_i(clk), .reset_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdd),
    .avs_waitrequest_o(wq), .sample_strobe_i(stb), .port_a_in_i(pin[15:0]),
    .port_a_out_o(ao), .port_a_oe_o(ae), .port_b_in_i(pin[31:16]), .port_b_out_o(bo),
    .port_b_oe_o(boe));
  dpd_field u_fld(.a_out_i(ao), .a_oe_i(ae), .b_out_i(bo), .b_oe_i(boe), .drv_i(drv),
    .drv_en_i(den), .pin_o(pin));
  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wq !== 1'b0 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      close_out;
    end
    q = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task fset(input int b, input logic v);
    @(posedge clk);
    drv[b] <= v;
    tick(3);
  endtask
  task pls(input int b);
    @(posedge clk);
    drv[b] <= 1'b1;
    @(posedge clk);
    drv[b] <= 1'b0;
    tick(1);
  endtask
  task s_reset;
    chk({boe, ae}, 32'hFFFF0000);
    bus(1'b0, `DPD_DIR_OFS, 32'h0);
    chk(q, 32'h0000000C);
  endtask
  task s_ports;
    drv <= 32'hA5A55A5A;
    bus(1'b1, `DPD_DIR_OFS, 32'h5);
    tick(1);
    chk({boe, ae}, 32'h00FF00FF);
    bus(1'b1, `DPD_OUT_OFS, 32'h12345678);
    be <= 4'h2;
    bus(1'b1, `DPD_OUT_OFS, 32'hFFFFFFFF);
    be <= 4'hF;
    tick(1);
    chk({bo, ao}, 32'h1234FF78);
    bus(1'b0, `DPD_IN_OFS, 32'h0);
    chk(q, 32'hA5345A78);
    bus(1'b1, 8'hFC, 32'hFFFFFFFF);
    bus(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
  endtask
  task s_samp;
    bus(1'b1, `DPD_DIR_OFS, 32'h0);
    drv <= 32'h0F0F3C3C;
    den <= 32'h00FFFFFF;
    tick(3);
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    drv <= 32'h0;
    den <= 32'hFFFFFFFF;
    bus(1'b0, `DPD_SAMP_OFS, 32'h0);
    chk(q, 32'h000F3C3C);
  endtask
  task s_plain;
    pls(0);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h14, 32'hFFFFFFFE);
    bus(1'b1, 8'h10, 32'h00000032);
    repeat (3) pls(18);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 8'h10, 32'h000C0032);
    pls(18);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h1);
  endtask
  task s_updown;
    bus(1'b1, 8'h18, 32'h00040964);
    repeat (2) pls(4);
    fset(5, 1'b1);
    repeat (3) pls(4);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q, 32'hFFFFFFFF);
    fset(5, 1'b0);
    bus(1'b1, 8'h1C, 32'h7FFFFFFF);
    pls(4);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h80000000);
  endtask
  task s_enc;
    bus(1'b1, 8'h20, 32'h000A89E6);
    fset(6, 1'b1);
    fset(7, 1'b1);
    fset(6, 1'b0);
    fset(7, 1'b0);
    fset(7, 1'b1);
    fset(6, 1'b1);
    bus(1'b0, 8'h24, 32'h0);
    chk(q, 32'h2);
    fset(8, 1'b1);
    fset(6, 1'b0);
    bus(1'b1, 8'h24, 32'h5);
    bus(1'b0, 8'h24, 32'h0);
    chk(q, 32'h0);
    fset(8, 1'b0);
    fset(6, 1'b1);
    bus(1'b0, 8'h24, 32'h0);
    chk(q, 32'hFFFFFFFF);
  endtask
  initial begin
    tick(20);
    rst_n <= 1'b1;
    s_reset;
    s_ports;
    s_samp;
    s_plain;
    s_updown;
    s_enc;
    rst_n <= 1'b0;
    tick(20);
    rst_n <= 1'b1;
    s_reset;
    close_out;
  end
endmodule
`default_nettype wire
